// ### core/doze_consts.svh
`ifndef DOZE_CONSTS_SVH
`define DOZE_CONSTS_SVH

// Register byte offsets
`define OFS_CLOCK_DIVIDER_CONTROL 8'h00
`define OFS_PWM_AUXILIARY_CONTROL 8'h04
`define OFS_MODULE_DISABLE_1      8'h08
`define OFS_MODULE_DISABLE_2      8'h0C
`define OFS_MODULE_DISABLE_3      8'h10
`define OFS_MODULE_DISABLE_4      8'h14

// Clock divider control fields
`define FULL_SPEED_ON_INTERRUPT_BIT 15
`define DOZE_RATIO_MSB              14
`define DOZE_RATIO_LSB              12
`define CPU_SLOWDOWN_ENABLE_BIT     11
`define CLOCK_DIVIDER_MASK          16'hF800

// PWM auxiliary control field bases
`define FINE_DUTY_OFF_LSB   0
`define FINE_PERIOD_OFF_LSB 16

// Implemented bits of the module-disable registers
`define MODULE_DISABLE_1_MASK 16'hFEFB
`define MODULE_DISABLE_2_MASK 16'h0F0F
`define MODULE_DISABLE_3_MASK 16'h0422
`define MODULE_DISABLE_4_MASK 16'h0008
`define PWM_GATE_BIT          9

// Reset values
`define CLOCK_DIVIDER_RESET  16'h0000
`define MODULE_DISABLE_RESET 16'h0000
`define PWM_AUX_RESET        32'h00000000

// Coarse step when fine resolution is off, picoseconds
`define COARSE_STEP_PS 8320

`endif

// ### core/doze_pkg.sv
package doze_pkg;

  typedef logic [15:0] reg_word_type;
  typedef logic [2:0]  doze_ratio_type;

  // Register selected by the current address
  typedef enum logic [2:0] {
    sel_none,
    sel_clock_divider,
    sel_pwm_aux,
    sel_disable_1,
    sel_disable_2,
    sel_disable_3,
    sel_disable_4
  } reg_select_type;

endpackage

// ### core/doze_and_module_clock_gating.sv
// Operation
// RULE1: Doze slows only the CPU enable; peripheral enables stay at full rate.
// RULE2: CPU enable is a gate on pclk, so both domains stay edge-aligned.
// RULE3: Setting clock divider bit 11 starts CPU slowdown.
// RULE4: Bits 14:12 pick ratio 1:1 up to 1:128, reset 1:1.
// RULE5: With bit 15 set, an interrupt restores full CPU speed.
// RULE6: With bit 15 clear, interrupts leave slowdown and ratio alone.
// RULE7: Fine duty off bit disables fine duty, phase and dead-time logic.
// RULE8: Fine period off bit disables fine period logic of that generator.
// RULE9: A set disable bit stops every clock to that peripheral.
// RULE10: A disabled peripheral ignores register writes; its reads are undefined.
// RULE11: Peripheral runs only when present and not disabled; disables reset clear.
// RULE12: Disable bit changes reach the peripheral one cycle after the write.
// RULE13: First disable register holds timers, decoder, PWM, serial, CAN, ADC.
// RULE14: Software must reinitialise PWM registers after PWM is re-enabled.
// RULE15: Second register holds capture four..one and compare four..one.
// RULE16: Third register holds comparator bit 10, decoder two 5, I2C two 1.
// RULE17: Unimplemented disable bits read zero and ignore writes.
// RULE18: Fourth register bit 3 disables the reference clock generator.
// RULE19: CPU clock is an enable pulse every N system cycles.
`include "doze_consts.svh"

module doze_and_module_clock_gating
  import doze_pkg::*;
#(
  parameter int          NUM_PWM_GEN     = 4,
  parameter logic [15:0] PRESENT_1       = 16'hFFFF,
  parameter logic [15:0] PRESENT_2       = 16'hFFFF,
  parameter logic [15:0] PRESENT_3       = 16'hFFFF,
  parameter logic [15:0] PRESENT_4       = 16'hFFFF
)
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   interrupt_request,
  output logic                        cpu_clock_enable,
  output logic      [NUM_PWM_GEN-1:0] fine_duty_enable,
  output logic      [NUM_PWM_GEN-1:0] fine_period_enable,
  output logic      [15:0]            module_run_1,
  output logic      [15:0]            module_run_2,
  output logic      [15:0]            module_run_3,
  output logic      [15:0]            module_run_4,
  output logic                        pwm_reinit_request
);

  // Interface summary for the next engineer:
  //  - register bus answers with zero wait states
  //  - read data is captured in the setup cycle
  //  - unmapped addresses answer with an error, write dropped
  //  - every gate output is a registered level
  //  - the CPU enable is a registered pulse train on pclk
  //  - nothing here makes a new clock; consumers gate with enables
  // Limitation: register width is fixed at 16 bits for the gate words
  // Trade-off: one extra cycle of gate latency for glitch-free outputs

  // Fine-resolution fields share one word, so the count is bounded
  generate
    if (NUM_PWM_GEN < 1 || NUM_PWM_GEN > 16)
    begin : g_check
      $error("NUM_PWM_GEN must lie between 1 and 16");
    end
  endgenerate

  // Register file state
  reg_word_type           clock_divider_control;
  logic [31:0]            pwm_auxiliary_control;
  reg_word_type           module_disable_1;
  reg_word_type           module_disable_2;
  reg_word_type           module_disable_3;
  reg_word_type           module_disable_4;
  reg_word_type           next_clock_divider_control;
  logic [31:0]            next_pwm_auxiliary_control;
  reg_word_type           next_module_disable_1;
  reg_word_type           next_module_disable_2;
  reg_word_type           next_module_disable_3;
  reg_word_type           next_module_disable_4;

  // Bus answer state
  logic [31:0]            next_prdata;
  logic                   next_pslverr;

  // Doze divider state
  logic [6:0]             doze_count;
  logic [6:0]             next_doze_count;
  logic                   next_cpu_clock_enable;

  // Output stage state
  logic [NUM_PWM_GEN-1:0] next_fine_duty_enable;
  logic [NUM_PWM_GEN-1:0] next_fine_period_enable;
  logic [15:0]            next_module_run_1;
  logic [15:0]            next_module_run_2;
  logic [15:0]            next_module_run_3;
  logic [15:0]            next_module_run_4;
  logic                   next_pwm_reinit_request;

  // Decode and field views
  reg_select_type         reg_select;
  logic                   setup_phase;
  logic                   write_strobe;
  logic                   slowdown_active;
  logic                   return_on_interrupt;
  doze_ratio_type         doze_ratio;
  logic [6:0]             ratio_last;
  logic [31:0]            pwm_aux_mask;

  // Mask of generator fields present in this build.
  // Bits beyond the generator count are never stored,
  // so a wide write from software cannot light up
  // a generator that does not exist.
  // Only implemented generator fields are writable
  always_comb
  begin
    pwm_aux_mask = 32'h00000000;
    for (int i = 0; i < NUM_PWM_GEN; i++)
    begin
      pwm_aux_mask[`FINE_DUTY_OFF_LSB + i]   = 1'b1;
      pwm_aux_mask[`FINE_PERIOD_OFF_LSB + i] = 1'b1;
    end
  end

  // Full-byte compare; misaligned addresses fall to sel_none.
  // Hazard: partial decode would alias holes onto live registers,
  // which would let a stray write flip a gate.
  // Address decode
  always_comb
  begin
    case (paddr)
      `OFS_CLOCK_DIVIDER_CONTROL: reg_select = sel_clock_divider;
      `OFS_PWM_AUXILIARY_CONTROL: reg_select = sel_pwm_aux;
      `OFS_MODULE_DISABLE_1:      reg_select = sel_disable_1;
      `OFS_MODULE_DISABLE_2:      reg_select = sel_disable_2;
      `OFS_MODULE_DISABLE_3:      reg_select = sel_disable_3;
      `OFS_MODULE_DISABLE_4:      reg_select = sel_disable_4;
      default:                    reg_select = sel_none;
    endcase
  end

  // Answer is prepared in setup, so access never waits
  assign setup_phase  = psel && !penable;
  assign write_strobe = psel && penable && pwrite;
  assign pready       = psel && penable;

  assign slowdown_active     = clock_divider_control[`CPU_SLOWDOWN_ENABLE_BIT];
  assign return_on_interrupt = clock_divider_control[`FULL_SPEED_ON_INTERRUPT_BIT];
  assign doze_ratio          = clock_divider_control[`DOZE_RATIO_MSB:`DOZE_RATIO_LSB];

  // Write path notes:
  //  - writes land at the access edge only
  //  - unimplemented bits are masked before storage
  //  - the interrupt clear comes last so it wins over a write
  //    that sets slowdown in the same cycle
  //  - a write to sel_none changes nothing
  // Why clear wins: an interrupt must never be left running slow
  // because software happened to re-arm slowdown at that moment.
  // Register writes and hardware clear of the slowdown bit
  always_comb
  begin
    next_clock_divider_control = clock_divider_control;
    next_pwm_auxiliary_control = pwm_auxiliary_control;
    next_module_disable_1      = module_disable_1;
    next_module_disable_2      = module_disable_2;
    next_module_disable_3      = module_disable_3;
    next_module_disable_4      = module_disable_4;
    if (write_strobe)
    begin
      case (reg_select)
        // RULE3: enable and ratio written
        sel_clock_divider: next_clock_divider_control = pwdata[15:0] & `CLOCK_DIVIDER_MASK;
        // RULE7: per-generator off bits
        sel_pwm_aux:       next_pwm_auxiliary_control = pwdata & pwm_aux_mask;
        // RULE13: first register layout
        sel_disable_1:     next_module_disable_1 = pwdata[15:0] & `MODULE_DISABLE_1_MASK;
        // RULE15: capture and compare bits
        sel_disable_2:     next_module_disable_2 = pwdata[15:0] & `MODULE_DISABLE_2_MASK;
        // RULE16: comparator, decoder, I2C
        sel_disable_3:     next_module_disable_3 = pwdata[15:0] & `MODULE_DISABLE_3_MASK;
        // RULE18: reference clock bit
        sel_disable_4:     next_module_disable_4 = pwdata[15:0] & `MODULE_DISABLE_4_MASK;
        default:           next_module_disable_4 = module_disable_4;
      endcase
    end
    // RULE5: interrupt returns to full speed
    // RULE6: no effect when option is clear
    if (return_on_interrupt && interrupt_request)
    begin
      next_clock_divider_control[`CPU_SLOWDOWN_ENABLE_BIT] = 1'b0;
    end
  end

  // Read data is loaded in setup and held until the next setup.
  // Holding it lets the master sample late in the access cycle
  // without seeing a changed value.
  // The error flag follows the same timing as the data.
  // Read mux; unimplemented bits are never stored, so they read zero
  always_comb
  begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setup_phase)
    begin
      next_pslverr = 1'b0;
      // RULE17: masked bits read as zero
      case (reg_select)
        sel_clock_divider: next_prdata = {16'h0000, clock_divider_control};
        sel_pwm_aux:       next_prdata = pwm_auxiliary_control;
        sel_disable_1:     next_prdata = {16'h0000, module_disable_1};
        sel_disable_2:     next_prdata = {16'h0000, module_disable_2};
        sel_disable_3:     next_prdata = {16'h0000, module_disable_3};
        sel_disable_4:     next_prdata = {16'h0000, module_disable_4};
        default:
        begin
          next_prdata  = 32'h00000000;
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  // Asynchronous reset puts every register at its power-on value.
  // Only constants appear in the reset branch.
  // Register file and bus answer flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_divider_control <= `CLOCK_DIVIDER_RESET;
      pwm_auxiliary_control <= `PWM_AUX_RESET;
      // RULE11: disables reset clear
      module_disable_1      <= `MODULE_DISABLE_RESET;
      module_disable_2      <= `MODULE_DISABLE_RESET;
      module_disable_3      <= `MODULE_DISABLE_RESET;
      module_disable_4      <= `MODULE_DISABLE_RESET;
      prdata                <= 32'h00000000;
      pslverr               <= 1'b0;
    end
    else
    begin
      clock_divider_control <= next_clock_divider_control;
      pwm_auxiliary_control <= next_pwm_auxiliary_control;
      module_disable_1      <= next_module_disable_1;
      module_disable_2      <= next_module_disable_2;
      module_disable_3      <= next_module_disable_3;
      module_disable_4      <= next_module_disable_4;
      prdata                <= next_prdata;
      pslverr               <= next_pslverr;
    end
  end

  // Ratio decode: code 0 gives a last count of 0 (1:1),
  // code 7 gives a last count of 127 (1:128).
  // The shift is done in eight bits and cut to seven on purpose.
  // RULE4: ratio code n gives 2 to the n
  assign ratio_last = 7'((8'h01 << doze_ratio) - 8'h01);

  // Divider behaviour:
  //  - counter runs 0 to last and wraps
  //  - enable is high on the cycle the counter returns to zero
  //  - a ratio change mid-run takes effect without a restart;
  //    a count above the new last wraps to zero at once
  //  - clearing slowdown forces the counter to zero
  // Limitation: the first pulse after a ratio change may come early.
  // Doze divider; counts only while slowed so 1:1 is exact when off
  always_comb
  begin
    next_doze_count = 7'h00;
    if (slowdown_active && (doze_count < ratio_last))
    begin
      // RULE19: count N system cycles
      next_doze_count = doze_count + 7'h01;
    end
    // RULE1: only the CPU enable thins out
    // RULE2: enable pulse stays on pclk edges
    next_cpu_clock_enable = !slowdown_active || (next_doze_count == 7'h00);
  end

  // Enable resets high so the CPU runs at full rate from reset.
  // Doze divider flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      doze_count       <= 7'h00;
      cpu_clock_enable <= 1'b1;
    end
    else
    begin
      doze_count       <= next_doze_count;
      cpu_clock_enable <= next_cpu_clock_enable;
    end
  end

  // Gate outputs:
  //  - run bits are the inverse of the disable bits
  //  - holes and absent peripherals always read as stopped
  //  - consumers use run low to block their own register writes
  //  - the PWM restart flag rises with the PWM run bit
  // Why registered: a combinational gate could glitch while the
  // register bus settles, and a glitch on a clock gate is a stray edge.
  // Gate enables; the extra stage gives the one-cycle settle
  always_comb
  begin
    // RULE7: fine duty, phase, dead time gate
    next_fine_duty_enable   = ~pwm_auxiliary_control[`FINE_DUTY_OFF_LSB +: NUM_PWM_GEN];
    // RULE8: fine period gate
    next_fine_period_enable = ~pwm_auxiliary_control[`FINE_PERIOD_OFF_LSB +: NUM_PWM_GEN];
    // RULE9: set disable bit stops the clock
    // RULE10: run low also blocks register writes
    // RULE11: absent peripherals never run
    // RULE12: applied one cycle after the write
    next_module_run_1 = ~module_disable_1 & `MODULE_DISABLE_1_MASK & PRESENT_1;
    next_module_run_2 = ~module_disable_2 & `MODULE_DISABLE_2_MASK & PRESENT_2;
    next_module_run_3 = ~module_disable_3 & `MODULE_DISABLE_3_MASK & PRESENT_3;
    next_module_run_4 = ~module_disable_4 & `MODULE_DISABLE_4_MASK & PRESENT_4;
    // RULE14: flag PWM restart so its registers start clean
    next_pwm_reinit_request = next_module_run_1[`PWM_GATE_BIT] && !module_run_1[`PWM_GATE_BIT];
  end

  // Reset values match the run bits computed from cleared disables,
  // so no false restart pulse follows reset.
  // Output flops; all peripherals start running when present
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fine_duty_enable   <= '1;
      fine_period_enable <= '1;
      module_run_1       <= `MODULE_DISABLE_1_MASK & PRESENT_1;
      module_run_2       <= `MODULE_DISABLE_2_MASK & PRESENT_2;
      module_run_3       <= `MODULE_DISABLE_3_MASK & PRESENT_3;
      module_run_4       <= `MODULE_DISABLE_4_MASK & PRESENT_4;
      pwm_reinit_request <= 1'b0;
    end
    else
    begin
      fine_duty_enable   <= next_fine_duty_enable;
      fine_period_enable <= next_fine_period_enable;
      module_run_1       <= next_module_run_1;
      module_run_2       <= next_module_run_2;
      module_run_3       <= next_module_run_3;
      module_run_4       <= next_module_run_4;
      pwm_reinit_request <= next_pwm_reinit_request;
    end
  end

  // Usage notes for integrators:
  //  - tie PRESENT bits low for peripherals absent in a build
  //  - the restart flag is one cycle wide; latch it if needed
  //  - software still owns the PWM register reinitialisation
  //  - fine enables cover only the generators present
  //  - the CPU enable must gate the core, never the peripherals

endmodule

// ### verif/doze_gating_assertions.sv
module doze_gating_assertions
  import doze_pkg::*;
#(
  parameter int NUM_PWM_GEN = 4
)
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   interrupt_request,
  input wire logic                   cpu_clock_enable,
  input wire logic [NUM_PWM_GEN-1:0] fine_duty_enable,
  input wire logic [NUM_PWM_GEN-1:0] fine_period_enable,
  input wire logic [15:0]            module_run_1,
  input wire logic [15:0]            module_run_3,
  input wire logic                   pwm_reinit_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write strobe at the access edge
  wire wr = psel && penable && pwrite;
  logic roi_q;
  logic slow_q;
  // Slowdown bit copy; when clear the divider sits at zero
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      slow_q <= 1'b0;
    else if (roi_q && interrupt_request)
      slow_q <= 1'b0;
    else if (wr && paddr == 8'h00)
      slow_q <= pwdata[11];
  // Wake bit copy, since no port shows it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      roi_q <= 1'b0;
    else if (wr && paddr == 8'h00)
      roi_q <= pwdata[15];
  a_ready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready not zero wait");
  a_run_one_map: assert property (wr && paddr == 8'h08 |-> ##2
    module_run_1 == (~$past(pwdata[15:0], 2) & 16'hFEFB)) else $error("module_run_1 map wrong");
  a_run_three_map: assert property (wr && paddr == 8'h10 |-> ##2
    module_run_3 == (~$past(pwdata[15:0], 2) & 16'h0422)) else $error("module_run_3 map wrong");
  a_reinit_pulse: assert property ($rose(module_run_1[9]) |-> pwm_reinit_request ##1 !pwm_reinit_request)
    else $error("reinit pulse wrong");
  a_doze_quarter_rate: assert property (!slow_q && wr && paddr == 8'h00 && pwdata[15:11] == 5'h05 |->
    ##2 !cpu_clock_enable [*3] ##1 cpu_clock_enable) else $error("ratio 2 pattern wrong");
  a_doze_release_full: assert property (wr && paddr == 8'h00 && !pwdata[11] |-> ##2 cpu_clock_enable [*2])
    else $error("cpu not full rate");
  a_wake_on_irq: assert property (roi_q && interrupt_request |-> ##2 cpu_clock_enable [*2])
    else $error("no wake on interrupt");
  a_fine_duty_map: assert property (wr && paddr == 8'h04 |-> ##2
    fine_duty_enable == ~$past(pwdata[NUM_PWM_GEN-1:0], 2)) else $error("fine duty wrong");
  a_fine_period_map: assert property (wr && paddr == 8'h04 |-> ##2
    fine_period_enable == ~$past(pwdata[16+NUM_PWM_GEN-1:16], 2)) else $error("fine period wrong");
  a_unmapped_error: assert property (psel && !penable && paddr > 8'h14 |=> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
endmodule

bind doze_and_module_clock_gating doze_gating_assertions #(.NUM_PWM_GEN(NUM_PWM_GEN)) i_doze_gating_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .interrupt_request(interrupt_request),
  .cpu_clock_enable(cpu_clock_enable), .fine_duty_enable(fine_duty_enable), .fine_period_enable(fine_period_enable),
  .module_run_1(module_run_1), .module_run_3(module_run_3), .pwm_reinit_request(pwm_reinit_request));

// ### verif/tb.sv
module tb
  import doze_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        interrupt_request = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, cpu_clock_enable, pwm_reinit_request;
  logic [3:0]  fine_duty_enable, fine_period_enable;
  logic [15:0] module_run_1, module_run_2, module_run_3, module_run_4;
  logic [15:0] run [4];
  logic [15:0] mask [4] = '{16'hFEFB, 16'h0F0F, 16'h0422, 16'h0008};
  logic [31:0] exp_q [$];
  logic [31:0] d;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cnt;
  assign run = '{module_run_1, module_run_2, module_run_3, module_run_4};
  always #50 pclk = ~pclk;
  doze_and_module_clock_gating i_doze_and_module_clock_gating (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .interrupt_request(interrupt_request),
    .cpu_clock_enable(cpu_clock_enable), .fine_duty_enable(fine_duty_enable), .fine_period_enable(fine_period_enable),
    .module_run_1(module_run_1), .module_run_2(module_run_2), .module_run_3(module_run_3),
    .module_run_4(module_run_4), .pwm_reinit_request(pwm_reinit_request));
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; a hung slave ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      n_fail++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads note the expected word for the watcher
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // Skips the settling edges, then counts CPU enables
  task automatic count_en(input int n);
    repeat (2) @(posedge pclk);
    cnt = 0;
    repeat (n)
    begin
      @(negedge pclk);
      cnt += (cpu_clock_enable === 1'b1);
    end
  endtask
  // Read data is taken at the edge where pready is sampled
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("prdata", exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEADBEEF, prdata);
  initial
  begin
    void'($urandom(32'hA0FD4105));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int r = 0; r < 6; r++)
      rd(8'(4 * r), 32'h0); // reset clear
    for (int r = 0; r < 4; r++)
      check("module_run", {16'h0, mask[r]}, {16'h0, run[r]}); // all enabled
    check("cpu_clock_enable", 32'h1, {31'h0, cpu_clock_enable}); // default ratio
    check("fine_enables", 32'hFF, {24'h0, fine_period_enable, fine_duty_enable}); // fine on
    // First register gets all ones so every gate and hole is hit
    for (int r = 0; r < 4; r++)
    begin
      d = (r == 0) ? 32'hFFFFFFFF : $urandom;
      apb(1'b1, 8'(8 + 4 * r), d);
      rd(8'(8 + 4 * r), d & {16'h0, mask[r]}); // holes read zero
      check("module_run", {16'h0, ~d[15:0] & mask[r]}, {16'h0, run[r]});
    end
    apb(1'b1, 8'h08, 32'h0);
    @(posedge pclk);
    #1 check("pwm_reinit_request", 32'h1, {31'h0, pwm_reinit_request}); // reinit pulse
    check("module_run", {16'h0, mask[0]}, {16'h0, run[0]}); // re-enable
    rd(8'h18, 32'h0);
    check("pslverr", 32'h1, {31'h0, pslverr});
    d = $urandom & 32'h000F000F;
    apb(1'b1, 8'h04, d);
    rd(8'h04, d); // read back
    check("fine_enables", {24'h0, ~d[19:16], ~d[3:0]}, {24'h0, fine_period_enable, fine_duty_enable});
    // Every ratio code: one enable per 2^n cycles
    for (int n = 0; n < 8; n++)
    begin
      // Slowdown off first, so each ratio starts from a known divider phase
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h00, {16'h0, 1'b0, 3'(n), 12'h800});
      count_en(256);
      check("cpu_rate", 32'(256 >> n), 32'(cnt));
      check("module_run", {16'h0, mask[0]}, {16'h0, run[0]}); // peripherals unslowed
    end
    rd(8'h00, 32'h7800); // slowdown bit
    // Interrupt with wake bit clear, then set
    for (int full_speed_on_interrupt = 0; full_speed_on_interrupt < 2; full_speed_on_interrupt++)
    begin
      apb(1'b1, 8'h00, 32'h3800 | 32'(full_speed_on_interrupt << 15));
      @(posedge pclk);
      interrupt_request <= 1'b1;
      @(posedge pclk);
      interrupt_request <= 1'b0;
      rd(8'h00, full_speed_on_interrupt ? 32'hB000 : 32'h3800); // slowdown bit
      count_en(64);
      check("cpu_rate", full_speed_on_interrupt ? 32'h40 : 32'h8, 32'(cnt)); // cpu rate
    end
    apb(1'b1, 8'h00, 32'h0);
    count_en(16);
    check("cpu_rate", 32'h10, 32'(cnt)); // full rate
    finish_test();
  end
endmodule
